// ===== pkg/exc_pkg.sv
// Constants for the exception recognition and reporting block
// Summary of operation
// - Misaligned, kernel-from-user, region mismatch: address error
// - Address error code 4 load/fetch, 5 store
// - System call gives code 8
// - Breakpoint gives code 9
// - Reserved instruction gives code 10
// - Unusable coprocessor gives code 11
// - Signed add/sub overflow gives code 12
// - True conditional trap gives code 13
// - Codes 6, 7 and 14-31 never produced
// - Illegal float opcode is reserved-instruction class
// - Unmasked pending interrupt, allowed at level 0, takes code 0 exception
// - Eleven-bit pending field shows live requests
// - Pending bits 0-1 are software set/clear
// - Pending bits 2-7 external, not software clearable
// - Cause bits 16/17 carry even/odd parity flags
// - Cause bit 18 is cycle counter MSB
// - Exception code sits in cause bits 7:3
// - Restart PC loads only when level was clear
// - All exceptions vector to base plus 0xc00
`default_nettype none
package exc_pkg;
  localparam int unsigned slots = 2;
  localparam logic [4:0] int_code = 5'h00;
  localparam logic [4:0] addr_fault_load_code = 5'h04;
  localparam logic [4:0] addr_fault_store_code = 5'h05;
  localparam logic [4:0] syscall_code = 5'h08;
  localparam logic [4:0] break_code = 5'h09;
  localparam logic [4:0] illegal_op_code = 5'h0a;
  localparam logic [4:0] cop_unusable_code = 5'h0b;
  localparam logic [4:0] arith_wrap_code = 5'h0c;
  localparam logic [4:0] compare_catch_code = 5'h0d;
  localparam logic [4:0] float_fault_code = illegal_op_code;
  localparam logic [63:0] vector_offset = 64'h0000_0000_0000_0c00;
  localparam logic [63:0] insn_bytes = 64'h0000_0000_0000_0004;
  // Register word offsets (byte addresses)
  localparam logic [4:0] status_off = 5'h00;
  localparam logic [4:0] cause_lo_off = 5'h04;
  localparam logic [4:0] cause_hi_off = 5'h08;
  localparam logic [4:0] restart_lo_off = 5'h0c;
  localparam logic [4:0] restart_hi_off = 5'h10;
  localparam logic [4:0] vbase_lo_off = 5'h14;
  localparam logic [4:0] vbase_hi_off = 5'h18;
  // Status field positions
  localparam int unsigned st_allow_bit = 0;
  localparam int unsigned st_level_bit = 1;
  localparam int unsigned st_user_bit = 2;
  localparam int unsigned st_mask_lsb = 16;
  // Cause field positions
  localparam int unsigned ca_code_lsb = 3;
  localparam int unsigned ca_flags_lsb = 8;
  localparam int unsigned ca_delay_bit_hi = 31;
  localparam int unsigned flag_bits = 11;
  // Reset values
  localparam logic [10:0] mask_rst = 11'h000;
  localparam logic [63:0] vbase_rst = 64'h0000_0000_0000_0000;
  // Region bits of a 64-bit address
  localparam int unsigned region_msb = 63;
  localparam int unsigned region_lsb = 62;
endpackage
`default_nettype wire

// ===== rtl/exc_unit.sv
// Exception recognition, cause/restart reporting and interrupt gating
//
// The register addresses and the Wishbone slave port are this design's own decisions.
`default_nettype none
module exc_unit (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Per-slot instruction status, slot 0 is oldest
  input wire logic [exc_pkg::slots-1:0] valid_i,
  input wire logic [exc_pkg::slots-1:0][63:0] pc_i,
  input wire logic [exc_pkg::slots-1:0] delay_slot_i,
  input wire logic [exc_pkg::slots-1:0] mem_req_i,
  input wire logic [exc_pkg::slots-1:0] mem_store_i,
  input wire logic [exc_pkg::slots-1:0][1:0] mem_size_i,
  input wire logic [exc_pkg::slots-1:0][63:0] mem_addr_i,
  input wire logic [exc_pkg::slots-1:0][63:0] mem_base_i,
  input wire logic [exc_pkg::slots-1:0] syscall_i,
  input wire logic [exc_pkg::slots-1:0] break_i,
  input wire logic [exc_pkg::slots-1:0] reserved_i,
  input wire logic [exc_pkg::slots-1:0] fp_illegal_i,
  input wire logic [exc_pkg::slots-1:0] cop_unusable_i,
  input wire logic [exc_pkg::slots-1:0] arith_i,
  input wire logic [exc_pkg::slots-1:0] arith_sub_i,
  input wire logic [exc_pkg::slots-1:0] arith_dword_i,
  input wire logic [exc_pkg::slots-1:0][63:0] op_a_i,
  input wire logic [exc_pkg::slots-1:0][63:0] op_b_i,
  input wire logic [exc_pkg::slots-1:0] trap_true_i,
  input wire logic [63:0] int_pc_i,
  input wire logic return_i,
  // Interrupt request sources
  input wire logic [5:0] ext_irq_i,
  input wire logic parity_even_i,
  input wire logic parity_odd_i,
  input wire logic count_msb_i,
  // Exception entry toward the pipeline
  output logic exc_take_o,
  output logic [63:0] exc_vector_o,
  output logic [4:0] exc_code_o,
  output logic [63:0] restart_pc_o,
  output logic exception_level_o,
  output logic user_mode_o
);
  import exc_pkg::*;

  typedef struct packed {
    logic irq_allow;
    logic exception_level_flag;
    logic user;
    logic [10:0] mask;
    logic [4:0] fault_kind_field;
    logic delay_slot_flag;
    logic [1:0] sw_flags;
    logic [63:0] restart_pc_reg;
    logic [63:0] vector_base_reg;
    logic ack;
    logic [31:0] rdata;
    logic take;
    logic [63:0] vector;
  } state_s;

  state_s cur_ff;
  state_s nxt_ff;
  logic [10:0] request_flags;
  logic user_eff;
  logic [slots-1:0] hit;
  logic [slots-1:0][4:0] code;
  logic precise;
  logic [4:0] p_code;
  logic [63:0] p_pc;
  logic p_delay;
  logic irq_go;
  logic bus_wr;
  logic bus_rd;
  logic [31:0] cause_lo;

  // Byte-lane merge of a write into a 32-bit word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Signed overflow of add or subtract, word or doubleword
  function automatic logic wraps(input logic [63:0] a, input logic [63:0] b,
                                 input logic sub, input logic dw);
    logic [63:0] bb;
    logic [63:0] r;
    logic s;
    bb = sub ? ~b : b;
    r = a + bb + {63'h0, sub};
    s = dw ? ((a[63] == bb[63]) && (r[63] != a[63]))
           : ((a[31] == bb[31]) && (r[31] != a[31]));
    return s;
  endfunction

  // Live pending field: software, external, parity, counter
  assign request_flags = {count_msb_i, parity_odd_i, parity_even_i, ext_irq_i, cur_ff.sw_flags};
  assign user_eff = cur_ff.user & ~cur_ff.exception_level_flag;

  // Per-slot fault decode, fixed priority inside one instruction
  always_comb begin
    for (int s = 0; s < slots; s++) begin
      logic [2:0] amask;
      logic addr_bad;
      amask = {mem_size_i[s] == 2'h3, mem_size_i[s][1], mem_size_i[s] != 2'h0};
      addr_bad = mem_req_i[s] && ((mem_addr_i[s][2:0] & amask) != 3'h0
                 || (user_eff && mem_addr_i[s][63])
                 || (mem_addr_i[s][region_msb:region_lsb] != mem_base_i[s][region_msb:region_lsb]));
      hit[s] = valid_i[s];
      code[s] = illegal_op_code;
      if (addr_bad) begin
        code[s] = mem_store_i[s] ? addr_fault_store_code : addr_fault_load_code;
      end else if (cop_unusable_i[s]) begin
        code[s] = cop_unusable_code;
      end else if (fp_illegal_i[s]) begin
        code[s] = float_fault_code;
      end else if (reserved_i[s]) begin
        code[s] = illegal_op_code;
      end else if (syscall_i[s]) begin
        code[s] = syscall_code;
      end else if (break_i[s]) begin
        code[s] = break_code;
      end else if (trap_true_i[s]) begin
        code[s] = compare_catch_code;
      end else if (arith_i[s] && wraps(op_a_i[s], op_b_i[s], arith_sub_i[s], arith_dword_i[s])) begin
        code[s] = arith_wrap_code;
      end else begin
        hit[s] = 1'b0;
      end
    end
  end

  // Oldest faulting slot is reported
  always_comb begin
    precise = 1'b0;
    p_code = int_code;
    p_pc = int_pc_i;
    p_delay = 1'b0;
    for (int s = slots - 1; s >= 0; s--) begin
      if (hit[s]) begin
        precise = 1'b1;
        p_code = code[s];
        p_delay = delay_slot_i[s];
        p_pc = delay_slot_i[s] ? pc_i[s] - insn_bytes : pc_i[s];
      end
    end
  end

  // Interrupt gating by mask, allow and level
  assign irq_go = ((request_flags & cur_ff.mask) != 11'h000) && cur_ff.irq_allow
                  && !cur_ff.exception_level_flag;

  assign bus_wr = cyc_i && stb_i && we_i && !cur_ff.ack;
  assign bus_rd = cyc_i && stb_i && !we_i && !cur_ff.ack;
  assign cause_lo = {13'h0000, request_flags, cur_ff.fault_kind_field, 3'h0};

  // Next-state: bus access, then exception entry on top
  always_comb begin
    logic [31:0] st_word;
    logic [31:0] ca_word;
    st_word = '0;
    ca_word = '0;
    nxt_ff = cur_ff;
    nxt_ff.ack = cyc_i && stb_i && !cur_ff.ack;
    nxt_ff.take = 1'b0;
    st_word[st_allow_bit] = cur_ff.irq_allow;
    st_word[st_level_bit] = cur_ff.exception_level_flag;
    st_word[st_user_bit] = cur_ff.user;
    st_word[st_mask_lsb +: flag_bits] = cur_ff.mask;
    if (bus_rd) begin
      unique case (adr_i)
        status_off: nxt_ff.rdata = st_word;
        cause_lo_off: nxt_ff.rdata = cause_lo;
        cause_hi_off: nxt_ff.rdata = {cur_ff.delay_slot_flag, 31'h0000_0000};
        restart_lo_off: nxt_ff.rdata = cur_ff.restart_pc_reg[31:0];
        restart_hi_off: nxt_ff.rdata = cur_ff.restart_pc_reg[63:32];
        vbase_lo_off: nxt_ff.rdata = cur_ff.vector_base_reg[31:0];
        vbase_hi_off: nxt_ff.rdata = cur_ff.vector_base_reg[63:32];
        default: nxt_ff.rdata = 32'h0000_0000;
      endcase
    end
    if (bus_wr) begin
      unique case (adr_i)
        status_off: begin
          st_word = merge(st_word, dat_i, sel_i);
          nxt_ff.irq_allow = st_word[st_allow_bit];
          nxt_ff.exception_level_flag = st_word[st_level_bit];
          nxt_ff.user = st_word[st_user_bit];
          nxt_ff.mask = st_word[st_mask_lsb +: flag_bits];
        end
        cause_lo_off: begin
          // Only the two software bits of the pending field take the write
          ca_word = merge(cause_lo, dat_i, sel_i);
          nxt_ff.sw_flags = ca_word[ca_flags_lsb +: 2];
        end
        restart_lo_off: nxt_ff.restart_pc_reg[31:0] = merge(cur_ff.restart_pc_reg[31:0], dat_i, sel_i);
        restart_hi_off: nxt_ff.restart_pc_reg[63:32] = merge(cur_ff.restart_pc_reg[63:32], dat_i, sel_i);
        vbase_lo_off: nxt_ff.vector_base_reg[31:0] = merge(cur_ff.vector_base_reg[31:0], dat_i, sel_i);
        vbase_hi_off: nxt_ff.vector_base_reg[63:32] = merge(cur_ff.vector_base_reg[63:32], dat_i, sel_i);
        default: nxt_ff.rdata = cur_ff.rdata;
      endcase
    end
    if (return_i) begin
      nxt_ff.exception_level_flag = 1'b0;
    end
    // Exception entry overrides a same-cycle software write of the level flag, and of the restart PC only when level was clear
    if (precise || irq_go) begin
      nxt_ff.take = 1'b1;
      nxt_ff.fault_kind_field = precise ? p_code : int_code;
      nxt_ff.delay_slot_flag = precise & p_delay;
      nxt_ff.vector = cur_ff.vector_base_reg + vector_offset;
      if (!cur_ff.exception_level_flag) begin
        nxt_ff.restart_pc_reg = precise ? p_pc : int_pc_i;
      end
      nxt_ff.exception_level_flag = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_ff <= '0;
      cur_ff.mask <= mask_rst;
      cur_ff.vector_base_reg <= vbase_rst;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // Outputs
  assign dat_o = cur_ff.rdata;
  assign ack_o = cur_ff.ack;
  assign exc_take_o = cur_ff.take;
  assign exc_vector_o = cur_ff.vector;
  assign exc_code_o = cur_ff.fault_kind_field;
  assign restart_pc_o = cur_ff.restart_pc_reg;
  assign exception_level_o = cur_ff.exception_level_flag;
  assign user_mode_o = user_eff;
endmodule
`default_nettype wire

// ===== verif/exc_unit_monitor.sv
// Concurrent checks on the exception unit ports
`default_nettype none
module exc_unit_monitor (
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic ack_o,
  // Pipeline side and entry outputs
  input wire logic [exc_pkg::slots-1:0] valid_i,
  input wire logic [exc_pkg::slots-1:0][63:0] pc_i,
  input wire logic [exc_pkg::slots-1:0] delay_slot_i,
  input wire logic [exc_pkg::slots-1:0] syscall_i,
  input wire logic exc_take_o,
  input wire logic [4:0] exc_code_o,
  input wire logic [63:0] restart_pc_o,
  input wire logic exception_level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import exc_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Fresh bus request, and a system call in the oldest slot at level zero
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_sys0;
    valid_i[0] && syscall_i[0] && !exception_level_o ##1 exc_code_o == 5'h08;
  endsequence
  a_ack_answer: assert property (s_req |=> ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  a_code_legal: assert property (exc_take_o |-> exc_code_o inside {5'h00, 5'h04, 5'h05, [5'h08:5'h0d]})
    else $error("reserved code reported");
  a_level_entry: assert property (exc_take_o |-> exception_level_o)
    else $error("level not set on entry");
  a_restart_hold: assert property (exc_take_o && $past(exception_level_o) && !$past(cyc_i && stb_i && we_i)
    |-> $stable(restart_pc_o))
    else $error("restart pc reloaded at level one");
  a_int_gated: assert property (exc_take_o && exc_code_o == 5'h00 |-> !$past(exception_level_o))
    else $error("interrupt taken at level one");
  a_precise_src: assert property (exc_take_o && exc_code_o != 5'h00 |-> $past(|valid_i))
    else $error("precise code without instruction");
  a_restart_point: assert property (s_sys0 |-> restart_pc_o == $past(pc_i[0]) - ($past(delay_slot_i[0]) ? 64'h4 : 64'h0))
    else $error("restart pc wrong");
endmodule
bind exc_unit exc_unit_monitor mon_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .ack_o(ack_o), .valid_i(valid_i), .pc_i(pc_i), .delay_slot_i(delay_slot_i), .syscall_i(syscall_i),
  .exc_take_o(exc_take_o), .exc_code_o(exc_code_o), .restart_pc_o(restart_pc_o),
  .exception_level_o(exception_level_o));
`default_nettype wire

// ===== verif/exc_unit_tb.sv
// Self-checking bench for the exception unit
`default_nettype none
module exc_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import exc_pkg::*;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, exc_take_o, exception_level_o, user_mode_o;
  logic parity_even_i, parity_odd_i, count_msb_i, return_i;
  logic [4:0] adr_i, exc_code_o;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [5:0] ext_irq_i, post, k0, k1;
  logic [1:0] valid_i, delay_slot_i, mem_req_i, mem_store_i, arith_i, arith_sub_i, arith_dword_i;
  logic [1:0][1:0] mem_size_i;
  logic [1:0][63:0] pc_i, mem_addr_i, mem_base_i, op_a_i, op_b_i;
  logic [63:0] int_pc_i, exc_vector_o, restart_pc_o;
  logic [4:0] ek [6] = '{5'h08, 5'h09, 5'h0a, 5'h0a, 5'h0b, 5'h0d};
  logic [63:0] ma [3] = '{64'h2, 64'h6, 64'h4000_0000_0000_0010};
  logic [63:0] oa [4] = '{64'h7fff_ffff, 64'h7fff_ffff_ffff_ffff, 64'hffff_ffff_8000_0000, 64'h8000_0000_0000_0000};
  int error_cnt, n_tests;
  // Decode flags: bit order syscall, break, reserved, fp illegal, coprocessor, trap
  exc_unit dut_u (.*, .syscall_i({k1[0], k0[0]}), .break_i({k1[1], k0[1]}), .reserved_i({k1[2], k0[2]}),
    .fp_illegal_i({k1[3], k0[3]}), .cop_unusable_i({k1[4], k0[4]}), .trap_true_i({k1[5], k0[5]}));
  irq_bus_model bus_u (.clk_i(clk_i), .rst_i(rst_i), .post_i(post), .ext_irq_o(ext_irq_i));
  // 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Classic Wishbone cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask
  // Present slot flags for one cycle, then check the entry
  task automatic fire(input logic [1:0] v, input logic [4:0] c, input logic [63:0] rpc);
    valid_i <= v;
    @(posedge clk_i);
    {valid_i, k0, k1, mem_req_i, arith_i} <= '0;
    #1;
    chk("take", 64'h1, {63'h0, exc_take_o});
    chk("code", {59'h0, c}, {59'h0, exc_code_o});
    chk("restart", rpc, restart_pc_o);
  endtask
  task automatic ret();
    @(posedge clk_i);
    return_i <= 1'b1;
    @(posedge clk_i);
    return_i <= 1'b0;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Sequence needs about 130 cycles; 4000 is a hang
  initial begin
    #20000;
    error_cnt++;
    stop_test();
  end
  // Main sequence
  initial begin
    {cyc_i, stb_i, we_i, return_i, parity_even_i, parity_odd_i, count_msb_i, adr_i, dat_i, post, k0, k1} = '0;
    {valid_i, delay_slot_i, mem_req_i, mem_store_i, arith_i, arith_sub_i, arith_dword_i, mem_size_i} = '0;
    {pc_i, mem_addr_i, mem_base_i, op_a_i, op_b_i, int_pc_i} = '0;
    {sel_i, error_cnt, n_tests, rst_i} = {4'hf, 64'h0, 1'b1};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 32; a += 4) begin
      wb(1'b0, 5'(a), 32'h0);
      chk("reset read", 64'h0, {32'h0, rd});
    end
    wb(1'b1, 5'h14, 32'h2000);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_i);
      k0 <= 6'h01 << i;
      pc_i[0] <= 64'(256 + 4 * i);
      fire(2'b01, ek[i], 64'(256 + 4 * i));
      chk("vector", 64'h2c00, exc_vector_o);
      ret();
    end
    $display("test codes done");
    @(posedge clk_i);
    {k0, k1, pc_i} <= {6'h02, 6'h01, 64'h204, 64'h200};
    fire(2'b11, 5'h09, 64'h200);
    ret();
    @(posedge clk_i);
    k1 <= 6'h01;
    fire(2'b10, 5'h08, 64'h204);
    ret();
    @(posedge clk_i);
    {k0, delay_slot_i} <= {6'h20, 2'b01};
    fire(2'b01, 5'h0d, 64'h1fc);
    wb(1'b0, 5'h08, 32'h0);
    chk("delay flag", 64'h1, {63'h0, rd[31]});
    {k0, delay_slot_i} <= {6'h04, 2'b00};
    fire(2'b01, 5'h0a, 64'h1fc);
    $display("test order done");
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 5'h00, {29'h0, i == 3, 2'b00});
      chk("user mode", 64'(i == 3), {63'h0, user_mode_o});
      {mem_req_i, mem_store_i[0], mem_size_i[0]} <= {2'b01, i == 1, 2'h2};
      mem_addr_i[0] <= (i == 3) ? 64'h8000_0000_0000_0010 : ma[i];
      mem_base_i[0] <= (i == 3) ? 64'h8000_0000_0000_0000 : 64'h0;
      fire(2'b01, (i == 1) ? 5'h05 : 5'h04, 64'h200);
    end
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 5'h00, 32'h0);
      {arith_i, arith_sub_i[0], arith_dword_i[0], op_a_i[0], op_b_i[0]} <= {2'b01, 2'(i), oa[i], 64'h1};
      fire(2'b01, 5'h0c, 64'h200);
    end
    @(posedge clk_i);
    {arith_i, arith_sub_i[0], arith_dword_i[0], op_a_i[0], valid_i} <= {2'b01, 2'b01, 64'h7fff_ffff, 2'b01};
    @(posedge clk_i);
    {valid_i, arith_i} <= '0;
    #1;
    chk("no wrap", 64'h0, {63'h0, exc_take_o});
    $display("test faults done");
    @(posedge clk_i);
    {post, parity_even_i, parity_odd_i, count_msb_i} <= {6'h25, 3'b101};
    wb(1'b1, 5'h04, 32'hffff_ffff);
    wb(1'b0, 5'h04, 32'h0);
    chk("pending", 64'h5_9760, {32'h0, rd & 32'h7_fff8});
    wb(1'b1, 5'h04, 32'h0);
    wb(1'b0, 5'h04, 32'h0);
    chk("sw clear", 64'h5_9460, {32'h0, rd & 32'h7_fff8});
    {int_pc_i, post, parity_even_i, count_msb_i} <= {64'h500, 8'h0};
    wb(1'b1, 5'h00, 32'h1_0000);
    wb(1'b1, 5'h04, 32'h100);
    repeat (4) @(posedge clk_i);
    chk("gated", 64'h0, {63'h0, exception_level_o});
    wb(1'b1, 5'h00, 32'h1_0001);
    repeat (2) @(posedge clk_i);
    #1;
    chk("int level", 64'h1, {63'h0, exception_level_o});
    chk("int code", 64'h0, {59'h0, exc_code_o});
    chk("int restart", 64'h500, restart_pc_o);
    $display("test interrupts done");
    stop_test();
  end
endmodule
`default_nettype wire

// ===== verif/irq_bus_model.sv
// Cache-controller bus model that posts external interrupt requests
`default_nettype none
module irq_bus_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Request word from the bench, and its bus copy
  input wire logic [5:0] post_i,
  output logic [5:0] ext_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // One bus transfer per cycle carries the latest request word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_irq_o <= 6'h00;
    end else begin
      ext_irq_o <= post_i;
    end
  end
endmodule
`default_nettype wire
